//--- pkg/mtp_consts.svh
`ifndef MTP_CONSTS_SVH
`define MTP_CONSTS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define MTP_CLK_NS 8
`define MTP_TICK_US 1000
`define MTP_TICK_CYCLES (`MTP_TICK_US * 1000 / `MTP_CLK_NS)
`define MTP_RISE_MS 60
`define MTP_END_MS 100
`define MTP_TAU_MS_PER_S 31
`define MTP_FAST_SH 10
`define MTP_BG_SH 13
// ----------------------------------------
// Scaling
// ----------------------------------------
`define MTP_IN_UNIT 16'h0100
`define MTP_PCT_RECIP 16'h028f
`define MTP_INIT_NUM 8'hb3
`define MTP_CNT_MAX 10'h3e7
`define MTP_P_MIN 7'h14
`define MTP_P_MAX 7'h64
`define MTP_KC_MIN 7'h01
`define MTP_KC_MAX 7'h40
`define MTP_IS_MIN 16'h0100
`define MTP_IS_MAX 16'h0a00
`define MTP_TS_MIN 16'h0003
`define MTP_TS_MAX 16'h0320
`define MTP_TS_MS 16'h0064
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MTP_R_FLC 4'h0
`define MTP_R_T6X 4'h1
`define MTP_R_P 4'h2
`define MTP_R_KC 4'h3
`define MTP_R_ALARM 4'h4
`define MTP_R_INHIB 4'h5
`define MTP_R_IS 4'h6
`define MTP_R_TS 4'h7
`define MTP_R_SW 4'h8
`define MTP_R_STAT 4'h9
`define MTP_R_LEVEL 4'ha
`define MTP_R_COUNT 4'hb
`define MTP_R_STIME 4'hc
`define MTP_R_RECI 4'hd
`define MTP_R_RECL 4'he
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MTP_FLC_RST 16'h0100
`define MTP_T6X_RST 16'h000a
`define MTP_P_RST 7'h32
`define MTP_KC_RST 7'h04
`define MTP_ALARM_RST 7'h5a
`define MTP_INHIB_RST 7'h50
`define MTP_IS_RST 16'h0300
`define MTP_TS_RST 16'h0032
`endif

//--- pkg/mtp_pkg.sv
`default_nettype none
package mtp_pkg;
    typedef enum logic [3:0] {
        ST_RUNNING = 4'b0001,
        ST_STILL = 4'b0010,
        ST_RISE = 4'b0100,
        ST_STARTUP = 4'b1000
    } mtp_sd_type;

    typedef struct packed {
        logic start_info_to_one;
        logic st_trip_to_three;
        logic st_trip_to_two;
        logic trip_latch_enable;
        logic startup_method_select;
        logic start_signal_route_switch;
        logic restart_inhibit_disable_switch;
        logic alarm_route_switch_b;
        logic alarm_route_switch_a;
    } mtp_sw_type;

    typedef struct packed {
        logic [15:0] phase_a;
        logic [15:0] phase_b;
        logic [15:0] phase_c;
    } mtp_phase_type;

    typedef struct packed {
        logic signal_output_one;
        logic signal_output_two;
        logic signal_output_three;
        logic thermal_trip;
        logic restart_enable;
    } mtp_relay_type;
endpackage : mtp_pkg
`default_nettype wire

//--- hw/mtp_protect.sv
// Notes on behaviour
// RQ1: Weighting factor between trip and background curves set 20 to 100 percent.
// RQ2: Largest phase current feeds the thermal replica.
// RQ3: Thermal time setting is cold trip time at six times full-load current.
// RQ4: Below full-load current only history is tracked, never an overload trip.
// RQ5: Level above alarm threshold gives prior alarm, routed by switches, code 1.
// RQ6: Level above 100 percent trips and shows code 2.
// RQ7: Above inhibit threshold restart-enable drops; code 3 once others acknowledged.
// RQ8: Inhibit disable switch set to 1 removes restart inhibit entirely.
// RQ9: Standstill when current below 12 percent of full-load current.
// RQ10: Standstill cooling uses heating constant times multiplier 1 to 64.
// RQ11: Start when current rises from standstill above 1.5 full-load within 60 ms.
// RQ12: Start-up ends after 100 ms below 1.25 full-load; time measured between.
// RQ13: Start counter increments per start, shows up to 999, then wraps.
// RQ14: Start clears indications, records fresh values, may drive output one.
// RQ15: Power-up sets replica to about 70 percent, then it follows current.
// RQ16: Both buttons held at power-up give a cold zero replica.
// RQ17: A switch selects definite-time or thermal-stress start-up supervision.
// RQ18: Definite-time stage trips after operate time, lights indicator, code 6.
// RQ19: Start-up stage indicator stays lit until the reset button clears it.
// RQ20: Stage start routes to output one; trip to outputs two or three.
// RQ21: Start current 1.0 to 10 rated, operate time 0.3 to 80 s.
// RQ22: Latch switch holds trip output after the fault until a reset source.
// RQ23: Five reset sources; program and keep command keep data, others erase.
// RQ24: Replica and timers update on a fixed tick from the system clock.
// RQ25: Trip needs comparison on consecutive samples; failure restarts the timer.
`default_nettype none
`include "mtp_consts.svh"
module mtp_protect
    import mtp_pkg::*;
#(
    parameter int TICK_CYC = `MTP_TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Measurement and control
    input wire mtp_phase_type phases,
    input wire logic [4:0] pins,
    input wire logic remote_reset_keep_data_cmd,
    input wire logic remote_reset_erase_data_cmd,
    // Relays and display
    output mtp_relay_type relays,
    output logic [2:0] display_code
);
    // ----------------------------------------
    // Pin synchronisers: step, program, speed, ext reset, spare
    // ----------------------------------------
    logic [4:0] s1_q, s2_q, s3_q, pin_q, pin_prev_q;
    for (genvar g = 0; g < 5; g++) begin : g_sync
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
                s3_q[g] <= 1'b0;
                pin_q[g] <= 1'b0;
                pin_prev_q[g] <= 1'b0;
            end else begin
                s1_q[g] <= pins[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (s2_q[g] == s3_q[g]) begin
                    pin_q[g] <= s3_q[g];
                end
                pin_prev_q[g] <= pin_q[g];
            end
        end
    end
    logic [4:0] pin_rise;
    assign pin_rise = pin_q & ~pin_prev_q;
    logic step_only, prog_only, step_prog, ext_reset;
    assign step_only = pin_rise[0] && !pin_q[1];
    assign prog_only = pin_rise[1] && !pin_q[0];
    assign step_prog = (pin_rise[0] && pin_q[1]) || (pin_rise[1] && pin_q[0]);
    assign ext_reset = pin_rise[3];
    logic reset_keep, reset_erase;
    assign reset_keep = prog_only || remote_reset_keep_data_cmd; // RQ23
    assign reset_erase = step_prog || remote_reset_erase_data_cmd || ext_reset; // RQ23

    // ----------------------------------------
    // Tick divider
    // ----------------------------------------
    logic [31:0] div_q;
    logic tick;
    assign tick = (div_q == 32'(TICK_CYC - 1));
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= 32'h0;
        end else begin
            div_q <= tick ? 32'h0 : div_q + 32'h1; // RQ24
        end
    end

    // ----------------------------------------
    // Settings
    // ----------------------------------------
    logic [15:0] flc_q, t6x_q, is_q, ts_q;
    logic [6:0] p_q, kc_q, alarm_q, inhib_q;
    mtp_sw_type sw_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flc_q <= `MTP_FLC_RST;
            t6x_q <= `MTP_T6X_RST;
            p_q <= `MTP_P_RST;
            kc_q <= `MTP_KC_RST;
            alarm_q <= `MTP_ALARM_RST;
            inhib_q <= `MTP_INHIB_RST;
            is_q <= `MTP_IS_RST;
            ts_q <= `MTP_TS_RST;
            sw_q <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                `MTP_R_FLC: flc_q <= reg_wdata;
                `MTP_R_T6X: t6x_q <= reg_wdata; // RQ3
                `MTP_R_P: p_q <= reg_wdata[6:0] < `MTP_P_MIN ? `MTP_P_MIN :
                                 reg_wdata[6:0] > `MTP_P_MAX ? `MTP_P_MAX : reg_wdata[6:0]; // RQ1
                `MTP_R_KC: kc_q <= reg_wdata[6:0] < `MTP_KC_MIN ? `MTP_KC_MIN :
                                   reg_wdata[6:0] > `MTP_KC_MAX ? `MTP_KC_MAX : reg_wdata[6:0]; // RQ10
                `MTP_R_ALARM: alarm_q <= reg_wdata[6:0];
                `MTP_R_INHIB: inhib_q <= reg_wdata[6:0];
                `MTP_R_IS: is_q <= reg_wdata < `MTP_IS_MIN ? `MTP_IS_MIN :
                                   reg_wdata > `MTP_IS_MAX ? `MTP_IS_MAX : reg_wdata; // RQ21
                `MTP_R_TS: ts_q <= reg_wdata < `MTP_TS_MIN ? `MTP_TS_MIN :
                                   reg_wdata > `MTP_TS_MAX ? `MTP_TS_MAX : reg_wdata; // RQ21
                `MTP_R_SW: sw_q <= reg_wdata[8:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Highest phase and level comparisons
    // ----------------------------------------
    logic [15:0] imax_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            imax_q <= 16'h0;
        end else begin
            imax_q <= (phases.phase_a >= phases.phase_b && phases.phase_a >= phases.phase_c) ? phases.phase_a :
                      (phases.phase_b >= phases.phase_c) ? phases.phase_b : phases.phase_c; // RQ2
        end
    end
    logic [19:0] i4, i25, f3, f5;
    logic [16:0] i2, f3h;
    assign i4 = {2'b0, imax_q, 2'b0};
    assign i25 = 20'(imax_q) * 20'h19;
    assign f3 = 20'(flc_q) * 20'h3;
    assign f5 = 20'(flc_q) * 20'h5;
    assign i2 = {imax_q, 1'b0};
    assign f3h = 17'(f3);
    logic standstill, over_start, under_end;
    assign standstill = i25 < f3; // RQ9
    assign over_start = i2 > f3h;
    assign under_end = i4 < f5;

    // ----------------------------------------
    // Thermal replica
    // ----------------------------------------
    // Fixed shifts keep the filter free of dividers; tau is set by the update period.
    logic [63:0] isq, fsq, cap, level, alarm_thr, inhib_thr;
    logic [33:0] fast_q, bg_q;
    logic [23:0] upd_q, period;
    logic init_q;
    assign isq = 64'(imax_q) * 64'(imax_q);
    assign fsq = 64'(flc_q) * 64'(flc_q);
    assign cap = fsq + (fsq >> 4) + (fsq >> 5) + (fsq >> 7);
    assign level = (((64'(fast_q) * 64'(p_q)) + (64'(bg_q) * 64'(`MTP_P_MAX - p_q)))
                    * 64'(`MTP_PCT_RECIP)) >> 16; // RQ1
    assign alarm_thr = (cap * 64'(alarm_q) * 64'(`MTP_PCT_RECIP)) >> 16;
    assign inhib_thr = (cap * 64'(inhib_q) * 64'(`MTP_PCT_RECIP)) >> 16;
    assign period = 24'(t6x_q) * 24'(`MTP_TAU_MS_PER_S) * (standstill ? 24'(kc_q) : 24'h1); // RQ3 RQ10
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            init_q <= 1'b1;
            upd_q <= 24'h0;
            fast_q <= 34'h0;
            bg_q <= 34'h0;
        end else if (tick) begin
            if (init_q) begin
                init_q <= 1'b0;
                fast_q <= (pin_q[0] && pin_q[1]) ? 34'h0 : 34'((cap * 64'(`MTP_INIT_NUM)) >> 8); // RQ15 RQ16
                bg_q <= (pin_q[0] && pin_q[1]) ? 34'h0 : 34'((cap * 64'(`MTP_INIT_NUM)) >> 8); // RQ15 RQ16
            end else if (upd_q + 24'h1 >= period) begin
                upd_q <= 24'h0;
                fast_q <= 34'($signed({1'b0, 34'(isq)}) - $signed({1'b0, fast_q}) >>> `MTP_FAST_SH)
                          + fast_q; // RQ24
                bg_q <= 34'($signed({1'b0, 34'(isq)}) - $signed({1'b0, bg_q}) >>> `MTP_BG_SH) + bg_q;
            end else begin
                upd_q <= upd_q + 24'h1;
            end
        end
    end
    logic th_trip_q, alarm_q_s, inhibit_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            th_trip_q <= 1'b0;
            alarm_q_s <= 1'b0;
            inhibit_q <= 1'b0;
        end else begin
            th_trip_q <= (level > cap) && (imax_q >= flc_q); // RQ4 RQ6
            alarm_q_s <= level > alarm_thr; // RQ5
            inhibit_q <= (level > inhib_thr) && !sw_q.restart_inhibit_disable_switch; // RQ7 RQ8
        end
    end

    // ----------------------------------------
    // Start detection and counting
    // ----------------------------------------
    mtp_sd_type sd_q;
    logic [6:0] win_q;
    logic [15:0] stime_q;
    logic [9:0] count_q;
    logic start_ev;
    assign start_ev = tick && (sd_q == ST_RISE) && over_start;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sd_q <= ST_RUNNING;
            win_q <= 7'h0;
        end else if (tick) begin
            case (sd_q)
                ST_RUNNING: sd_q <= standstill ? ST_STILL : ST_RUNNING; // RQ9
                ST_STILL: begin
                    win_q <= 7'h0;
                    if (!standstill) begin
                        sd_q <= ST_RISE;
                    end
                end
                ST_RISE: begin
                    win_q <= win_q + 7'h1;
                    if (over_start) begin
                        sd_q <= ST_STARTUP; // RQ11
                        win_q <= 7'h0;
                    end else if (standstill) begin
                        sd_q <= ST_STILL;
                    end else if (win_q >= 7'(`MTP_RISE_MS - 1)) begin
                        sd_q <= ST_RUNNING; // RQ11
                    end
                end
                ST_STARTUP: begin
                    win_q <= under_end ? win_q + 7'h1 : 7'h0;
                    if (under_end && win_q >= 7'(`MTP_END_MS - 1)) begin
                        sd_q <= ST_RUNNING; // RQ12
                    end
                end
                default: sd_q <= ST_RUNNING;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= 10'h0;
        end else if (start_ev) begin
            count_q <= (count_q == `MTP_CNT_MAX) ? 10'h0 : count_q + 10'h1; // RQ13
        end
    end
    logic [15:0] reci_q, recl_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stime_q <= 16'h0;
            reci_q <= 16'h0;
            recl_q <= 16'h0;
        end else if (start_ev) begin
            stime_q <= 16'h0;
            reci_q <= imax_q; // RQ14
            recl_q <= 16'(level >> 16); // RQ14
        end else if (reset_erase) begin
            stime_q <= 16'h0;
            reci_q <= 16'h0; // RQ23
            recl_q <= 16'h0; // RQ23
        end else if (tick && sd_q == ST_STARTUP && !under_end) begin
            stime_q <= stime_q + 16'h1; // RQ12
        end
    end

    // ----------------------------------------
    // Start-up supervision stage
    // ----------------------------------------
    // Stress mode sums I squared per ms against Is squared times ts.
    logic st_pick;
    logic [31:0] st_tmr_q;
    logic [63:0] stress_q, stress_lim;
    logic st_trip_q, st_hold_q, st_ind_q;
    assign st_pick = imax_q > is_q;
    assign stress_lim = 64'(is_q) * 64'(is_q) * 64'(ts_q) * 64'(`MTP_TS_MS);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_tmr_q <= 32'h0;
            stress_q <= 64'h0;
            st_trip_q <= 1'b0;
        end else if (!st_pick) begin
            st_tmr_q <= 32'h0; // RQ25
            stress_q <= 64'h0;
            st_trip_q <= 1'b0;
        end else if (tick && !pin_q[2]) begin
            st_tmr_q <= st_tmr_q + 32'h1; // RQ25
            stress_q <= stress_q + isq;
            if (sw_q.startup_method_select) begin
                st_trip_q <= stress_q + isq > stress_lim; // RQ17
            end else begin
                st_trip_q <= st_tmr_q + 32'h1 >= 32'(ts_q) * 32'(`MTP_TS_MS); // RQ17 RQ18
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_hold_q <= 1'b0;
        end else if (st_trip_q) begin
            st_hold_q <= sw_q.trip_latch_enable; // RQ22
        end else if (reset_keep || reset_erase) begin
            st_hold_q <= 1'b0; // RQ22 RQ23
        end
    end

    // ----------------------------------------
    // Indicators and display
    // ----------------------------------------
    // Set wins over clear so a trip in a clearing cycle stays visible.
    logic ind_alarm_q, ind_trip_q, ind_clr;
    assign ind_clr = step_only || start_ev || reset_erase; // RQ14 RQ19
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ind_alarm_q <= 1'b0;
            ind_trip_q <= 1'b0;
            st_ind_q <= 1'b0;
        end else begin
            ind_alarm_q <= alarm_q_s || (ind_alarm_q && !ind_clr);
            ind_trip_q <= th_trip_q || (ind_trip_q && !ind_clr);
            st_ind_q <= st_trip_q || (st_ind_q && !ind_clr); // RQ19
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            display_code <= 3'h0;
        end else begin
            display_code <= st_ind_q ? 3'h6 : ind_trip_q ? 3'h2 : ind_alarm_q ? 3'h1 : // RQ5 RQ6 RQ18
                            inhibit_q ? 3'h3 : 3'h0; // RQ7
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            relays <= '0;
        end else begin
            relays.signal_output_one <= (sw_q.start_signal_route_switch && st_pick) ||
                                        (sw_q.start_info_to_one && sd_q == ST_STARTUP); // RQ14 RQ20
            relays.signal_output_two <= (sw_q.st_trip_to_two && (st_trip_q || st_hold_q)) ||
                                        (sw_q.alarm_route_switch_a && alarm_q_s); // RQ5 RQ20
            relays.signal_output_three <= (sw_q.st_trip_to_three && (st_trip_q || st_hold_q)) ||
                                          (sw_q.alarm_route_switch_b && alarm_q_s); // RQ5 RQ20
            relays.thermal_trip <= th_trip_q; // RQ6
            relays.restart_enable <= !inhibit_q; // RQ7
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `MTP_R_FLC: reg_rdata <= flc_q;
                `MTP_R_T6X: reg_rdata <= t6x_q;
                `MTP_R_P: reg_rdata <= {9'h0, p_q};
                `MTP_R_KC: reg_rdata <= {9'h0, kc_q};
                `MTP_R_ALARM: reg_rdata <= {9'h0, alarm_q};
                `MTP_R_INHIB: reg_rdata <= {9'h0, inhib_q};
                `MTP_R_IS: reg_rdata <= is_q;
                `MTP_R_TS: reg_rdata <= ts_q;
                `MTP_R_SW: reg_rdata <= {7'h0, sw_q};
                `MTP_R_STAT: reg_rdata <= {4'h0, sd_q, st_hold_q, st_trip_q, inhibit_q, alarm_q_s,
                                           th_trip_q, display_code};
                `MTP_R_LEVEL: reg_rdata <= 16'(level >> 16);
                `MTP_R_COUNT: reg_rdata <= {6'h0, count_q};
                `MTP_R_STIME: reg_rdata <= stime_q;
                `MTP_R_RECI: reg_rdata <= reci_q;
                `MTP_R_RECL: reg_rdata <= recl_q;
                default: reg_rdata <= 16'h0;
            endcase
        end else begin
            reg_rdata <= 16'h0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_max_sel;
        @(posedge sys_clk) disable iff (!rstn)
        imax_q >= $past(phases.phase_a) && imax_q >= $past(phases.phase_b) && imax_q >= $past(phases.phase_c);
    endproperty
    a_max_sel: assert property (p_max_sel) else $error("max phase not selected"); // RQ2
    property p_no_trip_low;
        @(posedge sys_clk) disable iff (!rstn)
        (imax_q < flc_q) |=> !th_trip_q;
    endproperty
    a_no_trip_low: assert property (p_no_trip_low) else $error("trip below full load"); // RQ4
    property p_p_range;
        @(posedge sys_clk) disable iff (!rstn)
        p_q >= `MTP_P_MIN && p_q <= `MTP_P_MAX;
    endproperty
    a_p_range: assert property (p_p_range) else $error("weighting out of range"); // RQ1
    property p_kc_range;
        @(posedge sys_clk) disable iff (!rstn)
        kc_q >= `MTP_KC_MIN && kc_q <= `MTP_KC_MAX;
    endproperty
    a_kc_range: assert property (p_kc_range) else $error("cooling multiplier out of range"); // RQ10
    property p_count_step;
        @(posedge sys_clk) disable iff (!rstn)
        start_ev |=> count_q == (($past(count_q) == `MTP_CNT_MAX) ? 10'h0 : $past(count_q) + 10'h1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("start count wrong"); // RQ13
    property p_inhibit_off;
        @(posedge sys_clk) disable iff (!rstn)
        sw_q.restart_inhibit_disable_switch ##1 sw_q.restart_inhibit_disable_switch |=> relays.restart_enable;
    endproperty
    a_inhibit_off: assert property (p_inhibit_off) else $error("restart held while disabled"); // RQ8
    property p_code_six;
        @(posedge sys_clk) disable iff (!rstn)
        st_trip_q |=> st_ind_q ##1 display_code == 3'h6;
    endproperty
    a_code_six: assert property (p_code_six) else $error("stage trip not shown"); // RQ18
    property p_timer_restart;
        @(posedge sys_clk) disable iff (!rstn)
        !st_pick |=> st_tmr_q == 32'h0 && !st_trip_q;
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("timer not restarted"); // RQ25
    property p_latch_hold;
        @(posedge sys_clk) disable iff (!rstn)
        st_hold_q && !reset_keep && !reset_erase |=> st_hold_q;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched trip dropped"); // RQ22
endmodule : mtp_protect
`default_nettype wire

//--- test/mtp_plant.sv
`default_nettype none
module mtp_plant
    import mtp_pkg::*;
(
    // Stimulus side
    input wire logic [15:0] load,
    input wire logic [1:0] buttons,
    input wire logic ext_reset,
    // Device side
    output mtp_phase_type phases,
    output logic [4:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Measurement and front panel
    // ----------------------------------------
    // Unequal phases, largest on b, so a wrong pick shows
    assign phases = {load >> 1, load, load - (load >> 2)};
    // Speed switch idle; buttons and external reset pass through
    assign pins = {1'b0, ext_reset, 1'b0, buttons};
endmodule : mtp_plant
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench
    import mtp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals, clock, design and partner
    // ----------------------------------------
    logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, ext_rst = 0, keep_cmd = 0, erase_cmd = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, load = 16'h0000, reg_rdata, got;
    logic [1:0] btn = 2'h0;
    logic [2:0] display_code;
    mtp_relay_type relays;
    mtp_phase_type phases;
    logic [4:0] pins;
    int mismatches = 0, checks = 0, cyc = 0;
    logic [3:0] ca [8] = '{4'h2, 4'h2, 4'h3, 4'h3, 4'h6, 4'h6, 4'h7, 4'h7};
    logic [15:0] cw [8] = '{16'h0005, 16'h0070, 16'h0000, 16'h0050, 16'h0050, 16'h0b00, 16'h0001, 16'h0400};
    logic [15:0] ce [8] = '{16'h0014, 16'h0064, 16'h0001, 16'h0040, 16'h0100, 16'h0a00, 16'h0003, 16'h0320};
    logic [15:0] rv [8] = '{16'h0100, 16'h000a, 16'h0032, 16'h0004, 16'h005a, 16'h0050, 16'h0300, 16'h0032};
    always #4 sys_clk = ~sys_clk;
    mtp_protect #(.TICK_CYC(20)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phases(phases),
        .pins(pins), .remote_reset_keep_data_cmd(keep_cmd), .remote_reset_erase_data_cmd(erase_cmd),
        .relays(relays), .display_code(display_code));
    mtp_plant i_plant (.load(load), .buttons(btn), .ext_reset(ext_rst), .phases(phases), .pins(pins));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("Counts: checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask : rd
    task automatic boot(input logic [1:0] b);
        btn <= b;
        rstn <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (60) @(posedge sys_clk);
    endtask : boot
    // Ceiling well above the roughly 6800 cycles the tests need
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        boot(2'h0);
        for (int i = 0; i < 8; i++) begin
            rd(i[3:0]);
            chk(got, rv[i], "reset value");
        end
        // Level register is too coarse here; bracket the warm level by thresholds
        chk({15'h0, relays.restart_enable}, 16'h0001, "restart enable");
        wr(4'h4, 16'h0032);
        wr(4'h5, 16'h0032);
        repeat (5) @(posedge sys_clk);
        chk({13'h0, display_code}, 16'h0001, "warm level");
        chk({15'h0, relays.restart_enable}, 16'h0000, "restart inhibit");
        wr(4'h8, 16'h0004);
        repeat (5) @(posedge sys_clk);
        chk({15'h0, relays.restart_enable}, 16'h0001, "inhibit disabled");
        for (int i = 0; i < 8; i++) begin
            wr(ca[i], cw[i]);
            rd(ca[i]);
            chk(got, ce[i], "clamp");
        end
        wr(4'hf, 16'h1234);
        rd(4'hf);
        chk(got, 16'h0000, "unmapped");
        $display("Test registers done");
        wr(4'h6, 16'h0300);
        wr(4'h7, 16'h0003);
        wr(4'h8, 16'h0060);
        load <= 16'h0380;
        repeat (100) @(posedge sys_clk);
        rd(4'hb);
        chk(got, 16'h0001, "start count");
        rd(4'hd);
        chk(got, 16'h0380, "recorded current");
        repeat (6200) @(posedge sys_clk);
        chk({13'h0, display_code}, 16'h0006, "stage trip code");
        chk({15'h0, relays.signal_output_two}, 16'h0001, "trip routed");
        load <= 16'h0000;
        repeat (200) @(posedge sys_clk);
        chk({13'h0, display_code}, 16'h0006, "indicator held");
        chk({15'h0, relays.signal_output_two}, 16'h0001, "trip latched");
        keep_cmd <= 1'b1;
        @(posedge sys_clk);
        keep_cmd <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chk({15'h0, relays.signal_output_two}, 16'h0000, "latch released");
        btn <= 2'h1;
        repeat (40) @(posedge sys_clk);
        btn <= 2'h0;
        repeat (40) @(posedge sys_clk);
        chk({15'h0, display_code == 3'h6}, 16'h0000, "indicator cleared");
        erase_cmd <= 1'b1;
        @(posedge sys_clk);
        erase_cmd <= 1'b0;
        rd(4'hd);
        chk(got, 16'h0000, "recorded erased");
        $display("Test start-up stage done");
        boot(2'h3);
        rd(4'ha);
        chk(got, 16'h0000, "cold level");
        btn <= 2'h0;
        wr(4'h4, 16'h0032);
        repeat (5) @(posedge sys_clk);
        chk({13'h0, display_code}, 16'h0000, "cold alarm");
        $display("Test cold start done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
